// ===== rtl/fess_mem.sv
`timescale 1ns/1ps
`default_nettype none
module fess_mem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input wire logic clk, // clock
  input wire logic rst_b, // sync reset, output register only
  input wire logic [AW-1:0] a_addr, // engine address
  input wire logic a_we, // engine write
  input wire logic [DW-1:0] a_wd, // engine write data
  input wire logic a_re, // engine read
  output logic [DW-1:0] a_q, // engine read data, next cycle
  input wire logic [AW-1:0] b_addr, // host address
  input wire logic b_re, // host read
  input wire logic b_alt_sel, // host word comes from b_alt
  input wire logic [DW-1:0] b_alt, // non-array host word
  output logic [DW-1:0] b_q // host read data, next cycle
);
  logic [DW-1:0] mem_q [1<<AW];

  // cells start erased; reset leaves contents alone
  initial begin
    for (int i = 0; i < (1 << AW); i++) begin
      mem_q[i] = '1;
    end
  end

  always_ff @(posedge clk) begin
    if (a_we) begin
      mem_q[a_addr] <= a_wd;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      a_q <= '0;
    end else if (a_re) begin
      a_q <= mem_q[a_addr];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      b_q <= '0;
    end else if (b_re) begin
      b_q <= b_alt_sel ? b_alt : mem_q[b_addr];
    end
  end
endmodule // fess_mem
`default_nettype wire

// ===== rtl/fess_pkg.sv
package fess_pkg;
  localparam int DATA_W = 16;
  localparam int SR_W = 8;

  // bus command codes
  localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0020;
  localparam logic [DATA_W-1:0] CMD_BLANK_SETUP = 16'h00bc;
  localparam logic [DATA_W-1:0] CMD_PROG_SETUP = 16'h0040;
  localparam logic [DATA_W-1:0] CMD_CONFIRM = 16'h00d0;
  localparam logic [DATA_W-1:0] CMD_SUSPEND = 16'h00b0;
  localparam logic [DATA_W-1:0] CMD_CLEAR_STATUS = 16'h0050;
  localparam logic [DATA_W-1:0] CMD_READ_STATUS = 16'h0070;
  localparam logic [DATA_W-1:0] CMD_READ_ARRAY = 16'h00ff;
  localparam logic [DATA_W-1:0] CMD_READ_INFO = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_QUERY = 16'h0098;

  // data words
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
  localparam logic [DATA_W-1:0] INVALID_WORD = 16'h0000;
  localparam logic [DATA_W-1:0] INFO_WORD = 16'h0000;

  // status bit positions
  localparam int SR_READY = 7;
  localparam int SR_ESUSP = 6;
  localparam int SR_EERR = 5;
  localparam int SR_PERR = 4;
  localparam int SR_VPPERR = 3;
  localparam int SR_PSUSP = 2;
  localparam int SR_LOCKERR = 1;
  localparam int SR_PBUSY = 0;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SUSP_LAT_NS = 1000;
  localparam int SUSP_CYC = SUSP_LAT_NS / CLK_PERIOD_NS;
  localparam int PROG_NS = 500;
  localparam int PROG_CYC = (PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_PULSE_NS = 300;
  localparam int ERASE_PULSE_CYC = (ERASE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    RM_ARRAY = 2'b00,
    RM_STATUS = 2'b01,
    RM_INFO = 2'b10,
    RM_QUERY = 2'b11
  } fess_rmode_t;

  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_ERASE_CONF = 2'b01,
    CS_BLANK_CONF = 2'b10,
    CS_PROG_DATA = 2'b11
  } fess_cseq_t;

  typedef enum logic [1:0] {
    EP_PRE = 2'b00,
    EP_PULSE = 2'b01,
    EP_ERASE = 2'b10,
    EP_VERIFY = 2'b11
  } fess_ephase_t;
endpackage

// ===== rtl/fess_top.sv
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: erased block reads all ones; program only clears
// R2: erase is 0020h setup, 00D0h confirm
// R3: one erase at once; none under program-suspend
// R4: locked block or bad supply aborts erase
// R5: confirm latches block; precondition, erase, verify
// R6: ready bit low while erasing, high after
// R7: status bit 0 says which partition is busy
// R8: erase accepts only reads, status, suspend
// R9: reset aborts running or suspended work
// R10: blank check 00BCh/00D0h, refused during suspend
// R11: unerased block gives ready plus erase error
// R12: blank check takes only status read
// R13: only array program and erase suspend
// R14: suspend 00B0h keeps read mode
// R15: suspend lands after latency, sets suspend bit
// R16: lock, supply or protect change aborts suspended
// R17: suspend allows reads, clear, resume, erase-suspend program
// R18: suspended block unreadable; programming it errors
// R19: program under erase-suspend can suspend too
// R20: resume 00D0h continues, clears suspend bit
// R21: first resume restarts program, second erase
// R22: other partitions readable; busy one status only
// R23: 0050h clears error bits only
// R24: 0070h selects status-read mode
// R25: suspend with nothing active is ignored
module fess_top #(
  parameter int PART_W = 3,
  parameter int BLK_W = 1,
  parameter int WORD_W = 4
) (
  input wire logic core_clk, // device clock
  input wire logic rst_b, // sync reset, active low
  input wire logic [PART_W+BLK_W+WORD_W-1:0] bus_addr, // word address
  input wire logic [fess_pkg::DATA_W-1:0] bus_wdata, // command or data word
  input wire logic bus_wr, // write strobe
  input wire logic bus_rd, // read strobe
  output logic [fess_pkg::DATA_W-1:0] bus_rdata, // read word, cycle after strobe
  input wire logic vpp_ok, // programming supply valid
  input wire logic wp_b, // write-protect pin, active low
  input wire logic [(1<<(PART_W+BLK_W))-1:0] blk_lock, // per-block lock state
  output logic op_ready // registered device ready
);
  import fess_pkg::*;

  localparam int AW = PART_W + BLK_W + WORD_W;
  localparam int BW = PART_W + BLK_W;
  localparam int NPART = 1 << PART_W;
  localparam int SCW = $clog2(SUSP_CYC + 1);
  localparam int PCW = $clog2(PROG_CYC + ERASE_PULSE_CYC + 1);
  localparam logic [WORD_W-1:0] LAST_IDX = '1;

  if (PART_W < 1 || BLK_W < 0 || WORD_W < 1 || SUSP_CYC < 1 || PROG_CYC < 1) begin : g_bad
    $error("fess_top: unsupported geometry or timing");
  end

  fess_cseq_t cseq_q, cseq_d;
  fess_rmode_t rmode_q [NPART];
  logic eerr_q, perr_q, vpperr_q, lockerr_q;
  logic e_act_q, e_susp_q;
  fess_ephase_t e_ph_q;
  logic [BW-1:0] e_blk_q;
  logic [WORD_W-1:0] e_idx_q;
  logic b_act_q;
  logic [BW-1:0] b_blk_q;
  logic [WORD_W-1:0] b_idx_q;
  logic p_act_q, p_susp_q, p_step_q;
  logic [AW-1:0] p_addr_q;
  logic [DATA_W-1:0] p_data_q;
  logic [PCW-1:0] wait_q;
  logic s_pend_q;
  logic [SCW-1:0] s_cnt_q;
  logic rd_pend_q, wp_hold_q;

  logic p_run, e_run, busy, any_susp, s_hit, go;
  logic e_abort, p_abort, e_lock, p_lock, eng_e;
  logic start_erase, start_blank, start_prog, s_req, resume_e, resume_p, clr_err;
  logic dec_e, dec_p, dec_v, dec_l, to_status;
  logic [PART_W-1:0] wr_part, rd_part, busy_part;
  logic [BW-1:0] wr_blk, rd_blk, p_blk;
  logic [AW-1:0] a_addr;
  logic a_we, a_re, alt_sel;
  logic [DATA_W-1:0] a_wd, a_q, alt;
  logic [SR_W-1:0] sr;

  assign wr_part = bus_addr[AW-1 -: PART_W];
  assign wr_blk = bus_addr[AW-1 -: BW];
  assign rd_part = bus_addr[AW-1 -: PART_W];
  assign rd_blk = bus_addr[AW-1 -: BW];
  assign p_blk = p_addr_q[AW-1 -: BW];

  // program outranks erase: erase is always suspended underneath it
  assign p_run = p_act_q & ~p_susp_q;
  assign e_run = e_act_q & ~e_susp_q & ~p_run;
  assign busy = p_run | e_run | b_act_q; // R6 R11
  assign any_susp = e_susp_q | p_susp_q;
  assign busy_part = p_run ? p_addr_q[AW-1 -: PART_W] :
                     e_run ? e_blk_q[BW-1 -: PART_W] : b_blk_q[BW-1 -: PART_W];

  // stop only between memory accesses so a pending compare is not lost
  assign s_hit = s_pend_q & (s_cnt_q == '0) & ~rd_pend_q & (p_run | e_run); // R15
  assign go = ~s_hit;

  assign e_lock = e_act_q & blk_lock[e_blk_q];
  assign p_lock = p_act_q & blk_lock[p_blk];
  assign e_abort = e_act_q & (~vpp_ok | e_lock | (e_susp_q & (wp_b != wp_hold_q))); // R4 R16
  assign p_abort = p_act_q & (~vpp_ok | p_lock | (p_susp_q & (wp_b != wp_hold_q))); // R16

  // command decode
  always_comb begin
    cseq_d = cseq_q;
    start_erase = 1'b0;
    start_blank = 1'b0;
    start_prog = 1'b0;
    s_req = 1'b0;
    resume_e = 1'b0;
    resume_p = 1'b0;
    clr_err = 1'b0;
    dec_e = 1'b0;
    dec_p = 1'b0;
    dec_v = 1'b0;
    dec_l = 1'b0;
    to_status = 1'b0;
    if (bus_wr) begin
      unique case (cseq_q)
        CS_IDLE: begin
          if (bus_wdata == CMD_ERASE_SETUP && !busy && !any_susp) begin
            cseq_d = CS_ERASE_CONF; // R2 R3 R17
          end
          if (bus_wdata == CMD_BLANK_SETUP && !busy && !any_susp) begin
            cseq_d = CS_BLANK_CONF; // R10
          end
          if (bus_wdata == CMD_PROG_SETUP && !busy && !p_susp_q) begin
            cseq_d = CS_PROG_DATA; // R17
          end
          // blank check is never suspendable; idle suspend is dropped
          if (bus_wdata == CMD_SUSPEND && (p_run | e_run) && !s_pend_q) begin
            s_req = 1'b1; // R12 R13 R14 R19 R25
          end
          if (bus_wdata == CMD_CONFIRM && any_susp && !busy) begin
            resume_p = p_susp_q; // R20 R21
            resume_e = ~p_susp_q; // R21
          end
          if (bus_wdata == CMD_CLEAR_STATUS && !busy) begin
            clr_err = 1'b1; // R23
          end
        end
        CS_ERASE_CONF: begin
          cseq_d = CS_IDLE;
          to_status = 1'b1; // R5
          if (bus_wdata != CMD_CONFIRM) begin
            dec_e = 1'b1;
            dec_p = 1'b1;
          end else if (blk_lock[wr_blk]) begin
            dec_e = 1'b1; // R4
            dec_l = 1'b1;
          end else if (!vpp_ok) begin
            dec_e = 1'b1; // R4
            dec_v = 1'b1;
          end else begin
            start_erase = 1'b1; // R2 R5
          end
        end
        CS_BLANK_CONF: begin
          cseq_d = CS_IDLE;
          to_status = 1'b1; // R10
          if (bus_wdata != CMD_CONFIRM) begin
            dec_e = 1'b1;
            dec_p = 1'b1;
          end else begin
            start_blank = 1'b1; // R10
          end
        end
        CS_PROG_DATA: begin
          cseq_d = CS_IDLE;
          to_status = 1'b1;
          if (e_susp_q && wr_blk == e_blk_q) begin
            dec_p = 1'b1; // R18
          end else if (blk_lock[wr_blk]) begin
            dec_p = 1'b1;
            dec_l = 1'b1;
          end else if (!vpp_ok) begin
            dec_p = 1'b1;
            dec_v = 1'b1;
          end else begin
            start_prog = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cseq_q <= CS_IDLE;
    end else begin
      cseq_q <= cseq_d;
    end
  end

  // read modes: blank check blocks every mode change but status
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < NPART; i++) begin
        rmode_q[i] <= RM_ARRAY;
      end
    end else if (bus_wr) begin
      if (to_status) begin
        rmode_q[wr_part] <= RM_STATUS; // R5 R10
      end else if (cseq_q == CS_IDLE) begin
        if (bus_wdata == CMD_READ_STATUS) begin
          rmode_q[wr_part] <= RM_STATUS; // R7 R24
        end else if (!b_act_q && bus_wdata == CMD_READ_ARRAY) begin
          rmode_q[wr_part] <= RM_ARRAY; // R8 R12
        end else if (!b_act_q && bus_wdata == CMD_READ_INFO) begin
          rmode_q[wr_part] <= RM_INFO; // R8
        end else if (!b_act_q && bus_wdata == CMD_QUERY) begin
          rmode_q[wr_part] <= RM_QUERY; // R8
        end
      end
    end
  end

  // engine access to the array
  always_comb begin
    a_addr = '0;
    a_we = 1'b0;
    a_wd = ERASED_WORD;
    a_re = 1'b0;
    if (p_run) begin
      a_addr = p_addr_q;
      if (!p_step_q) begin
        a_re = go & ~rd_pend_q;
      end else if (rd_pend_q) begin
        a_we = 1'b1;
        a_wd = a_q & p_data_q; // R1
      end
    end else if (e_run) begin
      a_addr = {e_blk_q, e_idx_q};
      unique case (e_ph_q)
        EP_PRE: begin
          a_we = go;
          a_wd = ZERO_WORD; // R5
        end
        EP_PULSE: begin
        end
        EP_ERASE: begin
          a_we = go;
          a_wd = ERASED_WORD; // R1
        end
        EP_VERIFY: begin
          a_re = go & ~rd_pend_q; // R5
        end
      endcase
    end else if (b_act_q) begin
      a_addr = {b_blk_q, b_idx_q};
      a_re = ~rd_pend_q; // R10
    end
  end

  assign eng_e = rd_pend_q & (a_q != ERASED_WORD) &
                 ((e_run & (e_ph_q == EP_VERIFY)) | (~p_run & ~e_run & b_act_q)); // R11

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= a_re;
    end
  end

  // erase job
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      e_act_q <= 1'b0; // R9
      e_susp_q <= 1'b0;
      e_ph_q <= EP_PRE;
      e_blk_q <= '0;
      e_idx_q <= '0;
    end else if (e_abort) begin
      e_act_q <= 1'b0; // R4 R16
      e_susp_q <= 1'b0;
    end else if (start_erase) begin
      e_act_q <= 1'b1; // R3
      e_susp_q <= 1'b0;
      e_ph_q <= EP_PRE;
      e_blk_q <= wr_blk; // R5
      e_idx_q <= '0;
    end else begin
      if (s_hit && e_run) begin
        e_susp_q <= 1'b1; // R15
      end
      if (resume_e) begin
        e_susp_q <= 1'b0; // R20
      end
      if (e_run && go) begin
        unique case (e_ph_q)
          EP_PRE: begin
            e_idx_q <= e_idx_q + 1'b1;
            if (e_idx_q == LAST_IDX) begin
              e_ph_q <= EP_PULSE;
            end
          end
          EP_PULSE: begin
            if (wait_q == '0) begin
              e_ph_q <= EP_ERASE;
            end
          end
          EP_ERASE: begin
            e_idx_q <= e_idx_q + 1'b1;
            if (e_idx_q == LAST_IDX) begin
              e_ph_q <= EP_VERIFY;
            end
          end
          EP_VERIFY: begin
            if (rd_pend_q) begin
              e_idx_q <= e_idx_q + 1'b1;
              if (e_idx_q == LAST_IDX) begin
                e_act_q <= 1'b0; // R6
              end
            end
          end
        endcase
      end
    end
  end

  // blank check job, never suspended
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      b_act_q <= 1'b0;
      b_blk_q <= '0;
      b_idx_q <= '0;
    end else if (start_blank) begin
      b_act_q <= 1'b1; // R10
      b_blk_q <= wr_blk;
      b_idx_q <= '0;
    end else if (b_act_q && rd_pend_q) begin
      b_idx_q <= b_idx_q + 1'b1;
      if (b_idx_q == LAST_IDX) begin
        b_act_q <= 1'b0; // R11
      end
    end
  end

  // word program job: read, merge, write, then program time
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      p_act_q <= 1'b0; // R9
      p_susp_q <= 1'b0;
      p_step_q <= 1'b0;
      p_addr_q <= '0;
      p_data_q <= '0;
    end else if (p_abort) begin
      p_act_q <= 1'b0; // R16
      p_susp_q <= 1'b0;
    end else if (start_prog) begin
      p_act_q <= 1'b1;
      p_susp_q <= 1'b0;
      p_step_q <= 1'b0;
      p_addr_q <= bus_addr;
      p_data_q <= bus_wdata;
    end else begin
      if (s_hit && p_run) begin
        p_susp_q <= 1'b1; // R15 R19
      end
      if (resume_p) begin
        p_susp_q <= 1'b0; // R20 R21
      end
      if (p_run && go) begin
        if (!p_step_q) begin
          p_step_q <= 1'b1;
        end else if (!rd_pend_q && wait_q == '0) begin
          p_act_q <= 1'b0;
        end
      end
    end
  end

  // shared delay counter: program time or erase pulse, only one runs
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wait_q <= '0;
    end else if (p_run && go && p_step_q && rd_pend_q) begin
      wait_q <= PCW'(PROG_CYC - 1);
    end else if (e_run && go && e_ph_q == EP_PRE && e_idx_q == LAST_IDX) begin
      wait_q <= PCW'(ERASE_PULSE_CYC);
    end else if ((p_run || e_run) && go && wait_q != '0) begin
      wait_q <= wait_q - 1'b1;
    end
  end

  // suspend latency
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      s_pend_q <= 1'b0;
      s_cnt_q <= '0;
    end else if (s_req) begin
      s_pend_q <= 1'b1; // R14
      s_cnt_q <= SCW'(SUSP_CYC - 1); // R15
    end else if (s_hit || !(p_run || e_run)) begin
      s_pend_q <= 1'b0;
    end else if (s_cnt_q != '0) begin
      s_cnt_q <= s_cnt_q - 1'b1;
    end
  end

  // protect pin level frozen at the moment of suspend
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wp_hold_q <= 1'b1;
    end else if (s_hit) begin
      wp_hold_q <= wp_b; // R16
    end
  end

  // error bits: a set in the same cycle as a clear wins
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      eerr_q <= 1'b0;
      perr_q <= 1'b0;
      vpperr_q <= 1'b0;
      lockerr_q <= 1'b0;
    end else begin
      eerr_q <= (eerr_q & ~clr_err) | dec_e | eng_e | e_abort; // R4 R11 R23
      perr_q <= (perr_q & ~clr_err) | dec_p | p_abort; // R18 R23
      vpperr_q <= (vpperr_q & ~clr_err) | dec_v | ((e_abort | p_abort) & ~vpp_ok);
      lockerr_q <= (lockerr_q & ~clr_err) | dec_l | e_lock | p_lock;
    end
  end

  always_comb begin
    sr = '0;
    sr[SR_READY] = ~busy; // R6 R11
    sr[SR_ESUSP] = e_susp_q; // R15 R19
    sr[SR_EERR] = eerr_q;
    sr[SR_PERR] = perr_q;
    sr[SR_VPPERR] = vpperr_q;
    sr[SR_PSUSP] = p_susp_q; // R15 R19
    sr[SR_LOCKERR] = lockerr_q;
    sr[SR_PBUSY] = busy & (busy_part != rd_part); // R7
  end

  // host read word; the array port holds the word in its own register
  always_comb begin
    alt_sel = 1'b1;
    alt = INVALID_WORD;
    unique case (rmode_q[rd_part])
      RM_STATUS: begin
        alt = {{(DATA_W - SR_W){1'b0}}, sr}; // R22
      end
      RM_ARRAY: begin
        if (!(busy && busy_part == rd_part) &&
            !(e_susp_q && rd_blk == e_blk_q) && !(p_susp_q && rd_blk == p_blk)) begin
          alt_sel = 1'b0; // R8 R18 R22
        end
      end
      RM_INFO, RM_QUERY: begin
        if (!(busy && busy_part == rd_part)) begin
          alt = INFO_WORD; // R22
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      op_ready <= 1'b1;
    end else begin
      op_ready <= ~busy;
    end
  end

  fess_mem #(
    .AW(AW),
    .DW(DATA_W)
  ) u_mem (
    .clk(core_clk),
    .rst_b(rst_b),
    .a_addr(a_addr),
    .a_we(a_we),
    .a_wd(a_wd),
    .a_re(a_re),
    .a_q(a_q),
    .b_addr(bus_addr),
    .b_re(bus_rd),
    .b_alt_sel(alt_sel),
    .b_alt(alt),
    .b_q(bus_rdata)
  );
endmodule // fess_top
`default_nettype wire

// ===== tb/fess_host.sv
`timescale 1ns/1ps
`default_nettype none
module fess_host #(
  parameter int AW = 8
) (
  input wire logic core_clk, // clock
  output logic [AW-1:0] bus_addr, // address
  output logic [fess_pkg::DATA_W-1:0] bus_wdata, // write word
  output logic bus_wr, // write strobe
  output logic bus_rd, // read strobe
  input wire logic [fess_pkg::DATA_W-1:0] bus_rdata // read word
);
  import fess_pkg::*;
  initial begin
    bus_addr = '0;
    bus_wdata = '0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end
  // released lines flip so a stale word never passes for a driven one
  task automatic drop();
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    bus_addr <= ~bus_addr;
    bus_wdata <= ~bus_wdata;
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge core_clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    drop();
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge core_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    drop();
    #1;
    v = bus_rdata;
  endtask
  task automatic erase(input logic [AW-1:0] a);
    wr(a, CMD_ERASE_SETUP);
    wr(a, CMD_CONFIRM);
  endtask
  task automatic blank(input logic [AW-1:0] a);
    wr(a, CMD_BLANK_SETUP);
    wr(a, CMD_CONFIRM);
  endtask
  task automatic prog(input logic [AW-1:0] a, input logic [DATA_W-1:0] v);
    wr(a, CMD_PROG_SETUP);
    wr(a, v);
  endtask
  task automatic suspend(input logic [AW-1:0] a);
    wr(a, CMD_SUSPEND);
  endtask
  task automatic resume(input logic [AW-1:0] a);
    wr(a, CMD_CONFIRM);
  endtask
endmodule // fess_host
`default_nettype wire

// ===== tb/fess_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fess_sva #(
  parameter int PART_W = 3,
  parameter int BLK_W = 1,
  parameter int WORD_W = 4
) (
  input wire logic core_clk, // clock
  input wire logic rst_b, // sync reset
  input wire logic [PART_W+BLK_W+WORD_W-1:0] bus_addr, // address
  input wire logic [fess_pkg::DATA_W-1:0] bus_wdata, // write word
  input wire logic bus_wr, // write strobe
  input wire logic bus_rd, // read strobe
  input wire logic [fess_pkg::DATA_W-1:0] bus_rdata, // read word
  input wire logic vpp_ok, // supply valid
  input wire logic wp_b, // write protect
  input wire logic [(1<<(PART_W+BLK_W))-1:0] blk_lock, // lock state
  input wire logic op_ready // ready
);
  import fess_pkg::*;
  localparam int SUSP_MAX = SUSP_CYC + 8;
  logic [DATA_W-1:0] last_q;
  logic [1:0] susp_q;
  logic blank_q;
  logic conf;
  logic idle;
  logic setup;
  logic locked;
  // a setup is seen only through the word of the previous write
  assign conf = bus_wr && bus_wdata == CMD_CONFIRM;
  assign idle = op_ready && susp_q == 2'h0;
  assign setup = last_q == CMD_ERASE_SETUP || last_q == CMD_BLANK_SETUP;
  assign locked = blk_lock[bus_addr[PART_W+BLK_W+WORD_W-1:WORD_W]];
  always_ff @(posedge core_clk) begin
    if (!rst_b) last_q <= ZERO_WORD;
    else if (bus_wr) last_q <= bus_wdata;
  end
  // suspend depth; a protect-pin change or supply loss also ends it, a lock abort does not
  always_ff @(posedge core_clk) begin
    if (!rst_b || wp_b != $past(wp_b) || !vpp_ok) susp_q <= 2'h0;
    else if (bus_wr && bus_wdata == CMD_SUSPEND && !op_ready && !blank_q) susp_q <= susp_q + 2'h1;
    else if (conf && op_ready && susp_q != 2'h0 && !setup) susp_q <= susp_q - 2'h1;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) blank_q <= 1'b0;
    else if (conf && idle && last_q == CMD_BLANK_SETUP) blank_q <= 1'b1;
    else if ($rose(op_ready)) blank_q <= 1'b0;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_reset_ready: assert property ($rose(rst_b) |-> op_ready)
    else $error("ready low after reset");
  chk_erase_start: assert property (conf && idle && last_q == CMD_ERASE_SETUP && !locked && vpp_ok |-> ##2 !op_ready)
    else $error("erase did not start");
  chk_lock_abort: assert property (conf && idle && last_q == CMD_ERASE_SETUP && locked |=> op_ready [*3])
    else $error("locked block erase ran");
  chk_vpp_abort: assert property (!op_ready && !vpp_ok && !blank_q |-> ##[1:4] op_ready)
    else $error("bad supply did not abort");
  chk_suspend_lands: assert property (bus_wr && bus_wdata == CMD_SUSPEND && !op_ready && !blank_q |-> ##[2:SUSP_MAX] op_ready)
    else $error("suspend did not land");
  chk_resume_runs: assert property (conf && op_ready && susp_q != 2'h0 && !setup |-> ##2 !op_ready)
    else $error("resume did not restart");
  chk_blank_start: assert property (conf && idle && last_q == CMD_BLANK_SETUP |-> ##2 !op_ready)
    else $error("blank check did not start");
  chk_idle_stays: assert property (op_ready && !bus_wr && !$past(bus_wr) |=> op_ready)
    else $error("busy without a command");
  chk_rdata_hold: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data moved without read");
  cov_erase: cover property (conf && idle && last_q == CMD_ERASE_SETUP);
  cov_susp: cover property (susp_q != 2'h0 && op_ready);
  cov_blank: cover property (blank_q && !op_ready);
endmodule // fess_sva
bind fess_top fess_sva #(.PART_W(PART_W), .BLK_W(BLK_W), .WORD_W(WORD_W)) u_sva (
  .core_clk(core_clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .vpp_ok(vpp_ok), .wp_b(wp_b),
  .blk_lock(blk_lock), .op_ready(op_ready));
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fess_pkg::*;
  localparam logic [15:0] RDY = 16'h0001 << SR_READY;
  localparam logic [15:0] ESU = 16'h0001 << SR_ESUSP;
  localparam logic [15:0] EER = 16'h0001 << SR_EERR;
  localparam logic [15:0] PER = 16'h0001 << SR_PERR;
  localparam logic [15:0] VER = 16'h0001 << SR_VPPERR;
  localparam logic [15:0] LER = 16'h0001 << SR_LOCKERR;
  localparam logic [15:0] PBZ = 16'h0001 << SR_PBUSY;
  localparam logic [7:0] PA = 8'h12; // partition 0, block 1
  localparam logic [7:0] PC = 8'hc3; // partition 6, block 12
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic vpp_ok = 1'b1;
  logic wp_b = 1'b1;
  logic [15:0] blk_lock = 16'h0000;
  logic [7:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata;
  logic [DATA_W-1:0] bus_rdata;
  logic [DATA_W-1:0] d;
  logic bus_wr, bus_rd;
  logic op_ready;
  int error_cnt = 0;
  int compares = 0;
  always #50 core_clk = ~core_clk;
  fess_top dut (.core_clk(core_clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .vpp_ok(vpp_ok), .wp_b(wp_b),
    .blk_lock(blk_lock), .op_ready(op_ready));
  fess_host host (.core_clk(core_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic st(input logic [7:0] a, input logic [15:0] exp);
    host.wr(a, CMD_READ_STATUS);
    host.rd(a, d);
    check(d, exp);
  endtask
  task automatic arr(input logic [7:0] a, input logic [15:0] exp);
    host.wr(a, CMD_READ_ARRAY);
    host.rd(a, d);
    check(d, exp);
  endtask
  // blank check and erase are polled through the ready pin only
  task automatic wait_rdy();
    repeat (400) begin
      @(posedge core_clk);
      #1;
      if (op_ready === 1'b1) break;
    end
    check({15'h0000, op_ready}, 16'h0001);
  endtask
  task automatic t_idle();
    check({15'h0000, op_ready}, 16'h0001);
    arr(PA, ERASED_WORD);
    st(PA, RDY);
    host.suspend(PA);
    st(PA, RDY);
  endtask
  task automatic t_erase();
    host.prog(PA, 16'h1234);
    wait_rdy();
    host.prog(PA, 16'hff0f);
    wait_rdy();
    arr(PA, 16'h1204);
    host.blank(PA);
    wait_rdy();
    st(PA, RDY | EER);
    host.wr(PA, CMD_CLEAR_STATUS);
    st(PA, RDY);
    host.erase(PA);
    st(PC, PBZ);
    st(PA, ZERO_WORD);
    arr(PA, INVALID_WORD);
    arr(PC, ERASED_WORD);
    wait_rdy();
    host.rd(PA, d);
    check(d, ERASED_WORD);
    host.blank(PA);
    wait_rdy();
    st(PA, RDY);
  endtask
  task automatic suspend_latency();
    host.erase(PA);
    host.suspend(PA);
    repeat (SUSP_CYC + 3) @(posedge core_clk);
    host.rd(PA, d);
    check(d, RDY | ESU);
    host.wr(PA, CMD_ERASE_SETUP);
    host.wr(PA, CMD_BLANK_SETUP);
    st(PA, RDY | ESU);
    arr(PA, INVALID_WORD);
    host.prog(PA + 8'h01, ZERO_WORD);
    st(PA, RDY | ESU | PER);
    host.wr(PA, CMD_CLEAR_STATUS);
    st(PA, RDY | ESU);
    host.prog(PC, 16'h5a5a);
    wait_rdy();
    st(PC, RDY | ESU);
    arr(PC, 16'h5a5a);
    host.resume(PA);
    wait_rdy();
    st(PA, RDY);
    arr(PA, ERASED_WORD);
  endtask
  task automatic t_abort();
    blk_lock <= 16'h0002;
    host.erase(PA);
    st(PA, RDY | EER | LER);
    blk_lock <= 16'h0000;
    host.wr(PA, CMD_CLEAR_STATUS);
    host.erase(PA);
    repeat (5) @(posedge core_clk);
    vpp_ok <= 1'b0;
    wait_rdy();
    vpp_ok <= 1'b1;
    st(PA, RDY | EER | VER);
    host.wr(PA, CMD_CLEAR_STATUS);
    host.erase(PA);
    host.suspend(PA);
    repeat (SUSP_CYC + 3) @(posedge core_clk);
    wp_b <= 1'b0;
    repeat (3) @(posedge core_clk);
    st(PA, RDY | EER);
    wp_b <= 1'b1;
    host.wr(PA, CMD_CLEAR_STATUS);
    st(PA, RDY);
  endtask
  task automatic t_reset();
    host.erase(PA);
    host.suspend(PA);
    repeat (SUSP_CYC + 3) @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    check({15'h0000, op_ready}, 16'h0001);
    host.resume(PA);
    st(PA, RDY);
  endtask
  task automatic test_done();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_idle();
    t_erase();
    suspend_latency();
    t_abort();
    t_reset();
    test_done();
  end
  // run needs about 450 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    test_done();
  end
endmodule // testbench
`default_nettype wire
